// ### hw/spdp_map.svh
// Register indices, field positions, reset values and counts of the serial data path.
// Assumes byte address = 4 * index on a 32-bit APB; data sits in the low byte.
`ifndef SPDP_MAP_SVH
`define SPDP_MAP_SVH

// ----------------------------------------------------------------
// Register indices
// ----------------------------------------------------------------
`define SPDP_IDX_CTL 16'h7041
`define SPDP_IDX_STS 16'h7042
`define SPDP_IDX_DIV 16'h7044
`define SPDP_IDX_EMU 16'h7046
`define SPDP_IDX_BUF 16'h7047
`define SPDP_IDX_DAT 16'h7049
`define SPDP_IDX_PC1 16'h704d
`define SPDP_IDX_PC2 16'h704e

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define SPDP_STS_DONE    6
`define SPDP_PC_HI_DIN   7
`define SPDP_PC_HI_LSB   4
`define SPDP_PC_LO_DIN   3
`define SPDP_PC_LO_FUNC  1
`define SPDP_PC_LO_DIR   0

// ----------------------------------------------------------------
// Reset values and counts
// ----------------------------------------------------------------
`define SPDP_CTL_RESET      3'h0
`define SPDP_PIN_CFG_RESET  3'h0
`define SPDP_DATA_RESET     8'h00
`define SPDP_DIV_RESET      7'h00
`define SPDP_DIV_MIN        7'h03
`define SPDP_SLOW_PERIOD_M1 7'h03
`define SPDP_CHAR_BITS      8

`endif

// ### hw/spdp_pkg.sv
// Types shared by the serial data path modules.
// Assumes the constants come from spdp_map.svh.
package spdp_pkg;

    // Writable part of one pin's control nibble
    typedef struct packed {
        logic dout;
        logic func;
        logic dir;
    } spdp_pin_cfg_t;

    // One bit per serial pin; clk is bit 0
    typedef struct packed {
        logic somi;
        logic simo;
        logic ste;
        logic clk;
    } spdp_pins_t;

    typedef struct packed {
        logic master;
        logic talk;
        logic irq_en;
    } spdp_ctl_t;

    typedef enum logic [1:0] {
        SPDP_IDLE  = 2'b01,
        SPDP_SHIFT = 2'b10
    } spdp_state_t;

endpackage

// ### hw/spdp_rate_gen.sv
// Master serial clock generator: one bit period per divider setting.
// Assumes run is held for whole bit periods and dropped only after a fall event.
`timescale 1ns/1ns
`include "spdp_map.svh"

module spdp_rate_gen #(
    parameter int DIV_W = 7
) (
    input  wire logic             pclk,
    input  wire logic             presetn,
    input  wire logic             run,
    input  wire logic [DIV_W-1:0] divider,
    output logic                  sclk,
    output logic                  rise_evt,
    output logic                  fall_evt
);

    generate
        if (DIV_W < 3 || DIV_W > 7) begin : g_bad_width
            $error("spdp_rate_gen: DIV_W must lie in 3..7");
        end
    endgenerate

    logic [DIV_W-1:0] cnt;
    logic [DIV_W-1:0] next_cnt;
    logic [DIV_W-1:0] period_m1;
    logic [DIV_W-1:0] low_len;
    logic [DIV_W:0]   low_sum;

    // ----------------------------------------------------------------
    // Period selection
    // ----------------------------------------------------------------
    // period of divider plus one, four clocks for divider 0..2
    assign period_m1 = (divider < DIV_W'(`SPDP_DIV_MIN)) ?
                       DIV_W'(`SPDP_SLOW_PERIOD_M1) : divider;
    // Low half takes the odd cycle
    assign low_sum  = ({1'b0, period_m1} + (DIV_W+1)'(2)) >> 1;
    assign low_len  = low_sum[DIV_W-1:0];
    assign fall_evt = run && (cnt == period_m1);
    assign next_cnt = (!run || fall_evt) ? '0 : cnt + 1'b1;
    assign rise_evt = run && (next_cnt == low_len);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt  <= '0;
            sclk <= 1'b0;
        end else begin
            cnt  <= next_cnt;
            sclk <= run && (next_cnt >= low_len);
        end
    end

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    logic [DIV_W-1:0] gap;
    logic [DIV_W-1:0] div_q;
    logic             seen;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            gap   <= '0;
            seen  <= 1'b0;
            div_q <= '0;
        end else begin
            div_q <= divider;
            if (!run || divider != div_q) begin
                seen <= 1'b0;
                gap  <= '0;
            end else if (fall_evt) begin
                seen <= 1'b1;
                gap  <= '0;
            end else begin
                gap <= gap + 1'b1;
            end
        end
    end

    AST_RATE_FAST: assert property (@(posedge pclk) disable iff (!presetn)
        (fall_evt && seen && divider == div_q && divider >= DIV_W'(`SPDP_DIV_MIN))
        |-> gap == divider)
        else $error("bit period differs from divider plus one");

    AST_RATE_SLOW: assert property (@(posedge pclk) disable iff (!presetn)
        (fall_evt && seen && divider == div_q && divider < DIV_W'(`SPDP_DIV_MIN))
        |-> gap == DIV_W'(`SPDP_SLOW_PERIOD_M1))
        else $error("bit period is not four clocks");

endmodule

// ### hw/spdp_data_path.sv
// Serial port data path and pin control behind an APB register slave.
// Assumes one clock pclk; pins arrive asynchronously and are synchronised here.
//
// Notes on behaviour
// - master bit rate is clock over divider+1
// - divider 0..2 gives quarter clock rate
// - finished character copied to both buffers, flag set
// - reading receive buffer clears done flag
// - mirror buffer read leaves flag alone
// - bits enter MSB first, result right-justified
// - MSB sent each bit, LSB takes input
// - master write to shift register starts transfer
// - data driven out only with talk set
// - data-in bits show live pin, read-only
// - clock pin function, direction, data-out control
// - master-out pin function and I/O control
// - master-in pin function and I/O control
// - slave select function makes pin input only
// - master role: select pin always general I/O
// - shift logic clocked even with master-in as I/O
// - done flag at last bit, requests interrupt
// - role bit 0 slave, 1 master, reset slave
// - slave ignores divider; remote clock max eighth
//
// Register access over APB was left to the implementer.
`timescale 1ns/1ns
`include "spdp_map.svh"

module spdp_data_path #(
    parameter int CHAR_BITS = `SPDP_CHAR_BITS,
    parameter int DIV_W     = 7
) (
    input  wire logic                 pclk,
    input  wire logic                 presetn,
    input  wire logic                 psel,
    input  wire logic                 penable,
    input  wire logic                 pwrite,
    input  wire logic [17:0]          paddr,
    input  wire logic [31:0]          pwdata,
    output logic      [31:0]          prdata,
    output logic                      pready,
    output logic                      pslverr,
    input  wire spdp_pkg::spdp_pins_t pin_in,
    output spdp_pkg::spdp_pins_t      pin_out,
    output spdp_pkg::spdp_pins_t      pin_oe,
    output logic                      transfer_irq
);

    generate
        if (CHAR_BITS < 1 || CHAR_BITS > 8 || DIV_W < 3 || DIV_W > 7) begin : g_bad_param
            $error("spdp_data_path: CHAR_BITS must be 1..8 and DIV_W 3..7");
        end
    endgenerate

    // ----------------------------------------------------------------
    // Pin synchronisers
    // ----------------------------------------------------------------
    logic [3:0]           sync1;
    logic [3:0]           sync2;
    logic                 clk_d;
    spdp_pkg::spdp_pins_t pin_lvl;

    genvar gi;
    generate
        for (gi = 0; gi < 4; gi++) begin : g_sync
            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    sync1[gi] <= 1'b0;
                    sync2[gi] <= 1'b0;
                end else begin
                    sync1[gi] <= pin_in[gi];
                    sync2[gi] <= sync1[gi];
                end
            end
        end
    endgenerate

    assign pin_lvl = sync2;

    // ----------------------------------------------------------------
    // APB decode
    // ----------------------------------------------------------------
    wire        setup   = psel & ~penable;
    wire        access  = psel & penable;
    wire        wr      = access & pwrite;
    wire        rd      = access & ~pwrite;
    wire        addr_ok = (paddr[1:0] == 2'b00);
    wire [15:0] idx     = paddr[17:2];
    wire        hit_ctl = addr_ok && (idx == `SPDP_IDX_CTL);
    wire        hit_sts = addr_ok && (idx == `SPDP_IDX_STS);
    wire        hit_div = addr_ok && (idx == `SPDP_IDX_DIV);
    wire        hit_emu = addr_ok && (idx == `SPDP_IDX_EMU);
    wire        hit_buf = addr_ok && (idx == `SPDP_IDX_BUF);
    wire        hit_dat = addr_ok && (idx == `SPDP_IDX_DAT);
    wire        hit_pc1 = addr_ok && (idx == `SPDP_IDX_PC1);
    wire        hit_pc2 = addr_ok && (idx == `SPDP_IDX_PC2);
    wire        hit_any = hit_ctl | hit_sts | hit_div | hit_emu | hit_buf
                        | hit_dat | hit_pc1 | hit_pc2;

    // Zero wait states; unmapped words answer with an error
    assign pready  = 1'b1;
    assign pslverr = access & ~hit_any;

    // ----------------------------------------------------------------
    // Registers
    // ----------------------------------------------------------------
    spdp_pkg::spdp_ctl_t     ctl;
    spdp_pkg::spdp_pin_cfg_t ste_cfg;
    spdp_pkg::spdp_pin_cfg_t clk_cfg;
    spdp_pkg::spdp_pin_cfg_t simo_cfg;
    spdp_pkg::spdp_pin_cfg_t somi_cfg;
    spdp_pkg::spdp_state_t   state;
    spdp_pkg::spdp_state_t   next_state;
    logic [DIV_W-1:0]        div;
    logic [7:0]              sh;
    logic [7:0]              next_sh;
    logic [7:0]              rx_buf;
    logic [7:0]              rx_emu;
    logic [3:0]              bitcnt;
    logic                    done;
    logic                    sample;

    wire rd_buf = rd & hit_buf;
    wire wr_dat = wr & hit_dat;

    // reset makes every pin general input
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctl      <= `SPDP_CTL_RESET;
            div      <= DIV_W'(`SPDP_DIV_RESET);
            ste_cfg  <= `SPDP_PIN_CFG_RESET;
            clk_cfg  <= `SPDP_PIN_CFG_RESET;
            simo_cfg <= `SPDP_PIN_CFG_RESET;
            somi_cfg <= `SPDP_PIN_CFG_RESET;
        end else if (wr) begin
            if (hit_ctl) ctl <= pwdata[2:0];
            if (hit_div) div <= pwdata[DIV_W-1:0];
            if (hit_pc1) begin
                ste_cfg <= pwdata[`SPDP_PC_HI_LSB +: 3];
                clk_cfg <= pwdata[2:0];
            end
            if (hit_pc2) begin
                simo_cfg <= pwdata[`SPDP_PC_HI_LSB +: 3];
                somi_cfg <= pwdata[2:0];
            end
        end
    end

    // ----------------------------------------------------------------
    // Read mux
    // ----------------------------------------------------------------
    // data-in bits are live pin levels
    wire [7:0] rd_pc1 = {pin_lvl.ste, ste_cfg, pin_lvl.clk, clk_cfg};
    wire [7:0] rd_pc2 = {pin_lvl.simo, simo_cfg, pin_lvl.somi, somi_cfg};
    wire [7:0] rd_sts = {1'b0, done, 6'h00};
    wire [7:0] rd_mux = ({8{hit_ctl}} & {5'h00, ctl})
                      | ({8{hit_sts}} & rd_sts)
                      | ({8{hit_div}} & 8'(div))
                      | ({8{hit_emu}} & rx_emu)
                      | ({8{hit_buf}} & rx_buf)
                      | ({8{hit_dat}} & sh)
                      | ({8{hit_pc1}} & rd_pc1)
                      | ({8{hit_pc2}} & rd_pc2);

    // Captured in setup so the data stands through the access cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h0000_0000;
        end else if (setup) begin
            prdata <= {24'h00_0000, rd_mux};
        end
    end

    // ----------------------------------------------------------------
    // Serial clocking
    // ----------------------------------------------------------------
    wire master  = ctl.master;
    wire in_shift = (state == spdp_pkg::SPDP_SHIFT);
    wire run     = master & in_shift;
    logic gen_sclk;
    logic gen_rise;
    logic gen_fall;

    spdp_rate_gen #(
        .DIV_W    (DIV_W)
    ) spdp_rate_gen_inst (
        .pclk     (pclk),
        .presetn  (presetn),
        .run      (run),
        .divider  (div),
        .sclk     (gen_sclk),
        .rise_evt (gen_rise),
        .fall_evt (gen_fall)
    );

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            clk_d <= 1'b0;
        end else begin
            clk_d <= sync2[0];
        end
    end

    // Remote clock is seen through the synchroniser, hence the rate limit
    wire clk_rise_in = pin_lvl.clk & ~clk_d;
    wire clk_fall_in = ~pin_lvl.clk & clk_d;
    wire sel_active  = ~ste_cfg.func | ~pin_lvl.ste;

    // slave edges come from the pin only
    wire sample_evt = master ? gen_rise : (sel_active & clk_rise_in);
    wire shift_evt  = master ? gen_fall : (sel_active & clk_fall_in);
    // input sampled whatever the pin function
    wire rx_bit     = master ? pin_lvl.somi : pin_lvl.simo;
    // a dummy write is how software receives
    wire start_master = wr_dat & master & ~in_shift;
    wire complete     = in_shift & shift_evt & (bitcnt == 4'(CHAR_BITS - 1));

    // ----------------------------------------------------------------
    // Transfer sequencing
    // ----------------------------------------------------------------
    always_comb begin
        next_state = state;
        case (state)
            spdp_pkg::SPDP_IDLE: begin
                if (start_master || (!master && sample_evt)) begin
                    next_state = spdp_pkg::SPDP_SHIFT;
                end
            end
            spdp_pkg::SPDP_SHIFT: begin
                if (complete || (!master && !sel_active)) begin
                    next_state = spdp_pkg::SPDP_IDLE;
                end
            end
            default: next_state = spdp_pkg::SPDP_IDLE;
        endcase
    end

    // Master takes the line at the fall: two sync stages late, it shows the level at the rise.
    // Sampling at the rise would miss the new bit at a four-clock period.
    wire rx_in = master ? pin_lvl.somi : sample;

    // new bit enters at the LSB
    assign next_sh = {sh[6:0], rx_in};

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state  <= spdp_pkg::SPDP_IDLE;
            bitcnt <= 4'h0;
            sample <= 1'b0;
        end else begin
            state <= next_state;
            if (sample_evt) sample <= rx_bit;
            if (!in_shift) bitcnt <= 4'h0;
            else if (shift_evt) bitcnt <= bitcnt + 4'h1;
        end
    end

    // Writes during a character are dropped to keep it intact
    // shift MSB out, input in at LSB
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sh <= `SPDP_DATA_RESET;
        end else if (wr_dat && !in_shift) begin
            sh <= pwdata[7:0];
        end else if (in_shift && shift_evt) begin
            sh <= next_sh;
        end
    end

    // copy to both buffers with the flag
    // buffer read clears, a new character wins
    // flag set at the last bit
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rx_buf <= `SPDP_DATA_RESET;
            rx_emu <= `SPDP_DATA_RESET;
            done   <= 1'b0;
        end else begin
            if (complete) begin
                rx_buf <= next_sh;
                rx_emu <= next_sh;
            end
            done <= complete | (done & ~rd_buf);
        end
    end

    assign transfer_irq = done & ctl.irq_en;

    // ----------------------------------------------------------------
    // Pin control
    // ----------------------------------------------------------------
    // clock pin function and I/O
    assign pin_out.clk = clk_cfg.func ? gen_sclk : clk_cfg.dout;
    assign pin_oe.clk  = clk_cfg.func ? master : clk_cfg.dir;
    // serial data driven only with talk
    assign pin_out.simo = simo_cfg.func ? sh[7] : simo_cfg.dout;
    assign pin_oe.simo  = simo_cfg.func ? (master & ctl.talk) : simo_cfg.dir;
    assign pin_out.somi = somi_cfg.func ? sh[7] : somi_cfg.dout;
    assign pin_oe.somi  = somi_cfg.func ? (~master & ctl.talk & sel_active) : somi_cfg.dir;
    // master role keeps select as I/O
    assign pin_out.ste = ste_cfg.dout;
    assign pin_oe.ste  = (master | ~ste_cfg.func) & ste_cfg.dir;

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    AST_COPY: assert property (complete |=>
        done && rx_buf == $past(next_sh) && rx_emu == rx_buf)
        else $error("character not copied with flag");

    AST_RD_CLEAR: assert property ((rd_buf && !complete) |=> !done)
        else $error("buffer read did not clear flag");

    AST_EMU_KEEP: assert property ((setup && hit_emu && done)
        ##1 (rd && hit_emu) |=> done && prdata[7:0] == rx_emu)
        else $error("mirror read disturbed flag");

    AST_SHIFT_IN: assert property ((in_shift && shift_evt && !wr_dat) |=>
        sh == {$past(sh[6:0]), $past(master ? pin_lvl.somi : sample)})
        else $error("shift register did not take LSB");

    AST_START: assert property (start_master |=> in_shift ##[1:300] gen_fall)
        else $error("master write started no transfer");

    AST_TALK: assert property ((simo_cfg.func && master) |->
        pin_oe.simo == ctl.talk && pin_out.simo == sh[7])
        else $error("master data pin drive wrong");

    AST_DIN: assert property ((setup && hit_pc1) |=>
        prdata[`SPDP_PC_HI_DIN] == $past(pin_lvl.ste)
        && prdata[`SPDP_PC_LO_DIN] == $past(pin_lvl.clk))
        else $error("data-in bit not the live pin");

    AST_CLK_GPIO: assert property ((wr && hit_pc1 && !pwdata[`SPDP_PC_LO_FUNC]) |=>
        pin_oe.clk == $past(pwdata[`SPDP_PC_LO_DIR]))
        else $error("clock pin direction wrong");

    AST_STE_SLAVE: assert property ((!master && ste_cfg.func) |-> !pin_oe.ste)
        else $error("select pin driven in slave role");

    AST_STE_MASTER: assert property (master |-> pin_oe.ste == ste_cfg.dir)
        else $error("select pin not plain I/O in master role");

    AST_IRQ: assert property ((complete && ctl.irq_en) |=> transfer_irq)
        else $error("no interrupt request after character");

    COV_MASTER: cover property (master && complete);
    COV_SLAVE: cover property (!master && complete);
    COV_CLEAR: cover property (done ##1 rd_buf ##1 !done);

endmodule

// ### tb/spdp_far_slave.sv
// Behavioural serial slave on the far side of the data path's pins.
// Assumes clock idles low: samples master_out_pin on rise, shifts on fall.
`timescale 1ns/1ns

module spdp_far_slave (
    input  wire logic       serial_clock_pin,
    input  wire logic       master_out_pin,
    input  wire logic       load,
    input  wire logic [7:0] tx,
    output logic            master_in_pin,
    output logic [7:0]      got
);
    logic [7:0] sh = 8'h00;
    initial got = 8'h00;
    // whole 8-bit characters
    // Past the frame the line toggles instead of holding the last bit
    always @(posedge load or negedge serial_clock_pin) begin
        if (load) begin
            sh <= tx;
        end else begin
            sh <= {sh[6:0], ~sh[0]};
        end
    end
    always @(posedge serial_clock_pin) begin
        got <= {got[6:0], master_out_pin};
    end
    assign master_in_pin = sh[7];
endmodule

// ### tb/tb_spdp_data_path.sv
// Self-checking bench: APB master, pin wiring and far slave.
// Assumes zero-wait APB slave and the register map of spdp_map.svh.
`timescale 1ns/1ns
`include "spdp_map.svh"

module tb_spdp_data_path;
    logic                 pclk = 1'b0;
    logic                 presetn = 1'b0;
    logic                 psel = 1'b0;
    logic                 penable = 1'b0;
    logic                 pwrite = 1'b0;
    logic [17:0]          paddr = 18'h00000;
    logic [31:0]          pwdata = 32'h00000000;
    logic [31:0]          prdata;
    logic                 pready;
    logic                 pslverr;
    logic                 transfer_irq;
    spdp_pkg::spdp_pins_t pin_in;
    spdp_pkg::spdp_pins_t pin_out;
    spdp_pkg::spdp_pins_t pin_oe;
    logic                 far_load = 1'b0;
    logic [7:0]           far_tx = 8'h00;
    logic [7:0]           far_got;
    logic                 far_somi;
    logic                 gp_ste = 1'b0;
    logic                 gp_clk = 1'b0;
    logic                 gp_simo = 1'b0;
    integer               seed = 3144;
    int                   fails = 0;
    int                   samples_checked = 0;

    always #4 pclk = ~pclk;

    // Wire level: the driving party wins, else the outside level
    assign pin_in = {pin_oe.somi ? pin_out.somi : far_somi,
                     pin_oe.simo ? pin_out.simo : gp_simo,
                     pin_oe.ste ? pin_out.ste : gp_ste,
                     pin_oe.clk ? pin_out.clk : gp_clk};

    spdp_data_path spdp_data_path_inst (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .pin_in(pin_in),
        .pin_out(pin_out), .pin_oe(pin_oe), .transfer_irq(transfer_irq));

    spdp_far_slave spdp_far_slave_inst (
        .serial_clock_pin(pin_in.clk), .master_out_pin(pin_in.simo),
        .load(far_load), .tx(far_tx), .master_in_pin(far_somi), .got(far_got));

    // ------------------------------------------------------------
    // Bus, compare and closing tasks
    // ------------------------------------------------------------
    task automatic apb(input logic w, input logic [15:0] idx, input logic [7:0] wd,
                       output logic [31:0] rd, output logic err);
        int n;
        n = 0;
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= {idx, 2'b00};
        pwdata <= {24'h000000, wd};
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask

    task automatic wr(input logic [15:0] idx, input logic [7:0] d);
        logic [31:0] r;
        logic        e;
        apb(1'b1, idx, d, r, e);
    endtask

    task automatic rdr(input logic [15:0] idx, output logic [7:0] v);
        logic [31:0] r;
        logic        e;
        apb(1'b0, idx, 8'h00, r, e);
        v = r[7:0];
    endtask

    task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            fails++;
            $display("[FAIL] %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic wrap_up();
        $display("checked %0d mismatches %0d", samples_checked, fails);
        if (fails == 0 && samples_checked > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    // Pin enables expected with talk off
    function automatic logic [3:0] exp_oe(input logic [7:0] p1, p2, input logic m);
        exp_oe = {p2[1] ? 1'b0 : p2[0], p2[5] ? 1'b0 : p2[4],
                  (m | !p1[5]) & p1[4], p1[1] ? m : p1[0]};
    endfunction

    function automatic logic [3:0] gpio_out(input logic [7:0] p1, p2, input logic m);
        gpio_out = {!p2[1] & p2[0], !p2[5] & p2[4], (m | !p1[5]) & p1[4], !p1[1] & p1[0]};
    endfunction

    task automatic period(output int n);
        int k;
        n = 0;
        k = 0;
        while (pin_out.clk !== 1'b1 && k < 600) begin @(posedge pclk); k++; end
        while (pin_out.clk !== 1'b0 && k < 600) begin @(posedge pclk); k++; n++; end
        while (pin_out.clk !== 1'b1 && k < 600) begin @(posedge pclk); k++; n++; end
    endtask

    initial begin
        repeat (40000) @(posedge pclk);
        fails++;
        wrap_up();
    end

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        logic [7:0]  p1, p2, v, tx, rb, dv;
        logic [31:0] r;
        logic        e;
        int          n, k;
        logic [7:0]  divs [9] = '{8'h00, 8'h01, 8'h02, 8'h03, 8'h04, 8'h7f, 8'h00, 8'h00, 8'h00};
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        chk("oe_reset", pin_oe, 4'h0);
        apb(1'b0, 16'h7043, 8'h00, r, e);
        chk("unmapped_rd", r, 32'h0);
        chk("unmapped_err", e, 1'b1);
        // Random pin setups, slave role first then master
        for (int m = 0; m < 2; m++) begin
            wr(`SPDP_IDX_CTL, {m[0], 2'b00});
            for (int i = 0; i < 6; i++) begin
                p1 = $random(seed);
                p2 = $random(seed);
                wr(`SPDP_IDX_PC1, p1);
                wr(`SPDP_IDX_PC2, p2);
                rdr(`SPDP_IDX_PC1, v);
                chk("pc1", v, {pin_in.ste, p1[6:4], pin_in.clk, p1[2:0]});
                rdr(`SPDP_IDX_PC2, v);
                chk("pc2", v, {pin_in.simo, p2[6:4], pin_in.somi, p2[2:0]});
                chk("pin_oe", pin_oe, exp_oe(p1, p2, m[0]));
                chk("pin_out", pin_out & gpio_out(p1, p2, m[0]),
                    {p2[2], p2[6], p1[6], p1[2]} & gpio_out(p1, p2, m[0]));
            end
            // Deselect to abort any half character
            gp_ste <= 1'b1;
            wr(`SPDP_IDX_CTL, 8'h00);
            wr(`SPDP_IDX_PC1, 8'h20);
            repeat (4) @(posedge pclk);
        end
        wr(`SPDP_IDX_CTL, 8'h07);
        wr(`SPDP_IDX_PC1, 8'h02);
        for (int i = 0; i < 9; i++) begin
            dv = (i > 5) ? 8'h03 + ($unsigned($random(seed)) % 125) : divs[i];
            p2 = (i == 8) ? 8'h20 : 8'h22;
            wr(`SPDP_IDX_PC2, p2);
            wr(`SPDP_IDX_DIV, dv);
            tx = $random(seed);
            rb = $random(seed);
            far_tx <= rb;
            far_load <= 1'b1;
            @(posedge pclk);
            far_load <= 1'b0;
            wr(`SPDP_IDX_DAT, tx);
            period(n);
            chk("period", n, (dv < 3) ? 4 : dv + 1);
            k = 0;
            while (transfer_irq !== 1'b1 && k < 2000) begin @(posedge pclk); k++; end
            chk("irq", transfer_irq, 1'b1);
            chk("far_got", far_got, tx);
            rdr(`SPDP_IDX_EMU, v);
            chk("mirror", v, rb);
            rdr(`SPDP_IDX_STS, v);
            chk("done_kept", v[`SPDP_STS_DONE], 1'b1);
            rdr(`SPDP_IDX_BUF, v);
            chk("rx_buf", v, rb);
            rdr(`SPDP_IDX_STS, v);
            chk("done_clr", v[`SPDP_STS_DONE], 1'b0);
            chk("irq_clr", transfer_irq, 1'b0);
        end
        // Slave role: bench clocks the link at an eighth of pclk
        wr(`SPDP_IDX_CTL, 8'h03);
        gp_ste <= 1'b0;
        wr(`SPDP_IDX_PC1, 8'h22);
        wr(`SPDP_IDX_PC2, 8'h22);
        tx = $random(seed);
        dv = $random(seed);
        wr(`SPDP_IDX_DAT, dv);
        for (int b = 7; b >= 0; b--) begin
            gp_simo <= tx[b];
            repeat (4) @(posedge pclk);
            rb = {rb[6:0], pin_in.somi};
            gp_clk <= 1'b1;
            repeat (4) @(posedge pclk);
            gp_clk <= 1'b0;
        end
        repeat (8) @(posedge pclk);
        chk("slave_irq", transfer_irq, 1'b1);
        rdr(`SPDP_IDX_BUF, v);
        chk("slave_rx", v, tx);
        chk("slave_tx", rb, dv);
        wrap_up();
    end
endmodule
